// File: include/cfd_pkg.sv
/*
  Constants, register map and state codes of the charger fault and
  battery-detect sequencer. Assumes a 100 MHz core clock.
*/
// Function
// [RULE_01] Adapter-present pin on above sleep exit
// [RULE_02] Adapter-present pin off in sleep
// [RULE_03] Charge only while enable input low
// [RULE_04] Enable falling edge clears timers, faults
// [RULE_05] Timer fault high: wait fall, then detect
// [RULE_06] Reset or enable toggle clears timer fault
// [RULE_07] Timer fault low: apply removal-sense current
// [RULE_08] Rise while sensing: sense off, fault high
// [RULE_09] Overvoltage: PWM off, indicators off; the code acts on it in ST_CHARGE only, so ST_DONE keeps the done indicator on
// [RULE_10] Overvoltage latched until battery at recharge
// [RULE_11] Fall after charge done starts detection
// [RULE_12] First drain for interval, check short
// [RULE_13] Wake current for interval, check recharge
// [RULE_14] Both pass: report absent, no charge
// [RULE_15] Either fails: start new charge
// [RULE_16] Crossing while charging: second drain, redetect
// [RULE_17] Indicators: charging first, done second
// [RULE_18] Sync comparators; intervals from clock counters
// [RULE_19] One test current; PWM off meanwhile
package cfd_pkg;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h0c;
  localparam int CTRL_HOLD_BIT = 0;
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE = 0;
  localparam int IRQ_TFAULT = 1;
  localparam int IRQ_OVP = 2;
  localparam int IRQ_ABSENT = 3;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [IRQ_W-1:0] IRQ_RST = 4'h0;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam longint CLK_KHZ = 100000;
  localparam longint FIRST_DRAIN_MS = 1000;
  localparam longint WAKE_MS = 500;
  localparam longint SECOND_DRAIN_MS = 100;
  localparam longint SAFETY_S = 18000;
  localparam logic [31:0] FIRST_DRAIN_CYC = 32'(FIRST_DRAIN_MS * CLK_KHZ);
  localparam logic [31:0] WAKE_CYC = 32'(WAKE_MS * CLK_KHZ);
  localparam logic [31:0] SECOND_DRAIN_CYC = 32'(SECOND_DRAIN_MS * CLK_KHZ);
  localparam logic [43:0] SAFETY_CYC = 44'(SAFETY_S * CLK_KHZ * 1000);
  // ----------------------------------------
  // Sequencer states
  // ----------------------------------------
  typedef enum logic [3:0] {
    ST_SLEEP = 4'h0,
    ST_IDLE = 4'h1,
    ST_CHARGE = 4'h2,
    ST_DONE = 4'h3,
    ST_TF_HIGH = 4'h4,
    ST_TF_SENSE = 4'h5,
    ST_OVP = 4'h6,
    ST_DRAIN1 = 4'h7,
    ST_WAKE = 4'h8,
    ST_DRAIN2 = 4'h9,
    ST_ABSENT = 4'ha
  } cfd_state_e;
endpackage

// File: rtl/cfd_charger_seq.sv
/*
  Charger control sequencer: enable input, safety-timer fault recovery,
  overvoltage latch, battery-absent detection and status pins, with an
  AHB-Lite register slave. Assumes comparators and pins are asynchronous
  and the bus is zero-wait single word transfers.
*/
// Local design decisions: the AHB-Lite register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module cfd_charger_seq #(
  parameter logic [31:0] FIRST_DRAIN_CYCLES = cfd_pkg::FIRST_DRAIN_CYC,
  parameter logic [31:0] WAKE_CYCLES = cfd_pkg::WAKE_CYC,
  parameter logic [31:0] SECOND_DRAIN_CYCLES = cfd_pkg::SECOND_DRAIN_CYC,
  parameter logic [43:0] SAFETY_CYCLES = cfd_pkg::SAFETY_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  input wire logic chargeEnable_n,
  input wire logic supplyAboveSleepExit,
  input wire logic batAboveRecharge,
  input wire logic batBelowShort,
  input wire logic outOvervoltage,
  input wire logic chargeTerminated,
  output logic pwmEnable,
  output logic firstDrainOn,
  output logic wakeCurrentOn,
  output logic secondDrainOn,
  output logic removalSenseOn,
  output logic adapterPresentOut_n,
  output logic adapterPresentOe,
  output logic [1:0] indicatorOut_n,
  output logic [1:0] indicatorOe
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    cfd_pkg::cfd_state_e st;
    logic [31:0] cnt;
    logic [43:0] safety;
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic ceLast;
    logic batLast;
    logic aSel;
    logic aWrite;
    logic [7:0] aAddr;
    logic ctrlHold;
    logic [cfd_pkg::IRQ_W-1:0] irqStat;
    logic [cfd_pkg::IRQ_W-1:0] irqMask;
    logic [31:0] rdata;
    logic pwm;
    logic [3:0] currents;
    logic pgOn;
    logic [1:0] ind;
  } cfd_regs_s;

  cfd_regs_s cur_reg;
  cfd_regs_s cur_next;

  function automatic logic cfd_is_test(input cfd_pkg::cfd_state_e s);
    cfd_is_test = (s == cfd_pkg::ST_DRAIN1) || (s == cfd_pkg::ST_WAKE) ||
                  (s == cfd_pkg::ST_DRAIN2) || (s == cfd_pkg::ST_TF_SENSE);
  endfunction

  logic ceN;
  logic supOk;
  logic batHigh;
  logic batShort;
  logic ovp;
  logic termDone;
  logic ceFall;
  logic cntDone;
  logic [31:0] interval;
  logic [cfd_pkg::IRQ_W-1:0] irqSet;
  logic [cfd_pkg::IRQ_W-1:0] irqClr;
  logic dWr;

  assign ceN = cur_reg.sync2[0];
  assign supOk = cur_reg.sync2[1];
  assign batHigh = cur_reg.sync2[2];
  assign batShort = cur_reg.sync2[3];
  assign ovp = cur_reg.sync2[4];
  assign termDone = cur_reg.sync2[5];
  assign ceFall = cur_reg.ceLast && !ceN;
  assign dWr = cur_reg.aSel && cur_reg.aWrite;

  always_comb
  begin
    unique case (cur_reg.st)
      cfd_pkg::ST_DRAIN1: interval = FIRST_DRAIN_CYCLES;
      cfd_pkg::ST_WAKE: interval = WAKE_CYCLES;
      default: interval = SECOND_DRAIN_CYCLES;
    endcase
  end
  assign cntDone = (cur_reg.cnt >= interval - 32'h1);

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb
  begin
    cur_next = cur_reg;
    irqSet = '0;
    // Comparator and pin synchronisers [RULE_18]
    cur_next.sync1 = {chargeTerminated, outOvervoltage, batBelowShort,
                      batAboveRecharge, supplyAboveSleepExit, chargeEnable_n};
    cur_next.sync2 = cur_reg.sync1;
    cur_next.ceLast = ceN;
    // Past synced level for the removal crossing
    cur_next.batLast = batHigh;
    cur_next.cnt = cur_reg.cnt + 32'h1; // [RULE_18]
    if (cur_reg.st == cfd_pkg::ST_CHARGE)
    begin
      cur_next.safety = cur_reg.safety + 44'h1;
    end
    unique case (cur_reg.st)
      cfd_pkg::ST_SLEEP:
      begin
        cur_next.st = cfd_pkg::ST_IDLE;
      end
      cfd_pkg::ST_IDLE:
      begin
        if (!ceN && !cur_reg.ctrlHold)
        begin
          cur_next.st = cfd_pkg::ST_CHARGE; // [RULE_03]
        end
      end
      cfd_pkg::ST_CHARGE:
      begin
        if (ovp)
        begin
          cur_next.st = cfd_pkg::ST_OVP; // [RULE_09]
          irqSet[cfd_pkg::IRQ_OVP] = 1'b1;
        end
        else if (cur_reg.safety >= SAFETY_CYCLES - 44'h1)
        begin
          cur_next.st = batHigh ? cfd_pkg::ST_TF_HIGH : cfd_pkg::ST_TF_SENSE; // [RULE_05] [RULE_07]
          irqSet[cfd_pkg::IRQ_TFAULT] = 1'b1;
        end
        else if (termDone)
        begin
          cur_next.st = cfd_pkg::ST_DONE;
          irqSet[cfd_pkg::IRQ_DONE] = 1'b1;
        end
        else if (cur_reg.batLast && !batHigh)
        begin
          cur_next.st = cfd_pkg::ST_DRAIN2; // [RULE_16]
          cur_next.cnt = '0;
        end
      end
      cfd_pkg::ST_DONE:
      begin
        if (!batHigh)
        begin
          cur_next.st = cfd_pkg::ST_DRAIN1; // [RULE_11]
          cur_next.cnt = '0;
        end
      end
      cfd_pkg::ST_TF_SENSE:
      begin
        if (batHigh)
        begin
          cur_next.st = cfd_pkg::ST_TF_HIGH; // [RULE_08]
        end
      end
      cfd_pkg::ST_TF_HIGH:
      begin
        if (!batHigh)
        begin
          cur_next.st = cfd_pkg::ST_DRAIN1; // [RULE_05]
          cur_next.cnt = '0;
          cur_next.safety = '0;
        end
      end
      cfd_pkg::ST_OVP:
      begin
        if (!batHigh)
        begin
          cur_next.st = cfd_pkg::ST_CHARGE; // [RULE_10]
        end
      end
      cfd_pkg::ST_DRAIN1:
      begin
        if (cntDone)
        begin
          cur_next.cnt = '0;
          cur_next.st = batShort ? cfd_pkg::ST_WAKE : cfd_pkg::ST_CHARGE; // [RULE_12] [RULE_15]
          cur_next.safety = '0;
        end
      end
      cfd_pkg::ST_WAKE:
      begin
        if (cntDone)
        begin
          cur_next.cnt = '0;
          cur_next.safety = '0;
          if (batHigh)
          begin
            cur_next.st = cfd_pkg::ST_ABSENT; // [RULE_13] [RULE_14]
            irqSet[cfd_pkg::IRQ_ABSENT] = 1'b1;
          end
          else
          begin
            cur_next.st = cfd_pkg::ST_CHARGE; // [RULE_15]
          end
        end
      end
      cfd_pkg::ST_DRAIN2:
      begin
        if (cntDone)
        begin
          cur_next.cnt = '0;
          cur_next.st = cfd_pkg::ST_ABSENT; // [RULE_16]
          irqSet[cfd_pkg::IRQ_ABSENT] = 1'b1;
        end
      end
      cfd_pkg::ST_ABSENT:
      begin
        cur_next.cnt = '0;
        cur_next.st = cfd_pkg::ST_DRAIN1; // [RULE_16]
      end
      default:
      begin
        cur_next.st = cfd_pkg::ST_IDLE;
      end
    endcase
    // Enable input and software hold override the sequence
    if (ceN || cur_reg.ctrlHold)
    begin
      cur_next.st = cfd_pkg::ST_IDLE; // [RULE_03]
    end
    if (ceFall && !cur_reg.ctrlHold)
    begin
      cur_next.st = cfd_pkg::ST_CHARGE; // [RULE_04] [RULE_06]
      cur_next.cnt = '0;
      cur_next.safety = '0;
    end
    if (!supOk)
    begin
      cur_next.st = cfd_pkg::ST_SLEEP;
    end
    // ----------------------------------------
    // Registered pin drive
    // ----------------------------------------
    cur_next.pwm = (cur_next.st == cfd_pkg::ST_CHARGE) && !ovp &&
                   !cfd_is_test(cur_next.st); // [RULE_09] [RULE_19]
    cur_next.currents = {cur_next.st == cfd_pkg::ST_TF_SENSE,
                         cur_next.st == cfd_pkg::ST_DRAIN2,
                         cur_next.st == cfd_pkg::ST_WAKE,
                         cur_next.st == cfd_pkg::ST_DRAIN1}; // [RULE_19]
    cur_next.pgOn = supOk; // [RULE_01] [RULE_02]
    cur_next.ind = {cur_next.st == cfd_pkg::ST_DONE,
                    cur_next.st == cfd_pkg::ST_CHARGE}; // [RULE_17]
    // ----------------------------------------
    // Bus slave
    // ----------------------------------------
    cur_next.aSel = hsel && htrans[1] && hready;
    cur_next.aWrite = hwrite;
    cur_next.aAddr = haddr[7:0];
    irqClr = '0;
    if (dWr)
    begin
      unique case (cur_reg.aAddr)
        cfd_pkg::CTRL_OFS: cur_next.ctrlHold = hwdata[cfd_pkg::CTRL_HOLD_BIT];
        cfd_pkg::IRQ_STAT_OFS: irqClr = hwdata[cfd_pkg::IRQ_W-1:0];
        cfd_pkg::IRQ_MASK_OFS: cur_next.irqMask = hwdata[cfd_pkg::IRQ_W-1:0];
        default: cur_next.ctrlHold = cur_reg.ctrlHold;
      endcase
    end
    cur_next.irqStat = (cur_reg.irqStat & ~irqClr) | irqSet;
    cur_next.rdata = '0;
    if (hsel && htrans[1] && hready && !hwrite)
    begin
      unique case (haddr[7:0])
        cfd_pkg::CTRL_OFS: cur_next.rdata = {31'h0, cur_reg.ctrlHold};
        cfd_pkg::STAT_OFS: cur_next.rdata = {24'h0, cur_reg.ind, 2'h0, cur_reg.st};
        cfd_pkg::IRQ_STAT_OFS: cur_next.rdata = {28'h0, cur_reg.irqStat};
        cfd_pkg::IRQ_MASK_OFS: cur_next.rdata = {28'h0, cur_reg.irqMask};
        default: cur_next.rdata = '0;
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cur_reg <= '0; // [RULE_06]
      cur_reg.st <= cfd_pkg::ST_SLEEP;
      cur_reg.sync1 <= 6'h01;
      cur_reg.sync2 <= 6'h01;
      cur_reg.ceLast <= 1'b1;
      cur_reg.ctrlHold <= cfd_pkg::CTRL_RST;
      cur_reg.irqStat <= cfd_pkg::IRQ_RST;
      cur_reg.irqMask <= cfd_pkg::IRQ_RST;
    end
    else
    begin
      cur_reg <= cur_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign hrdata = cur_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign irq = |(cur_reg.irqStat & cur_reg.irqMask);
  assign pwmEnable = cur_reg.pwm;
  assign firstDrainOn = cur_reg.currents[0];
  assign wakeCurrentOn = cur_reg.currents[1];
  assign secondDrainOn = cur_reg.currents[2];
  assign removalSenseOn = cur_reg.currents[3];
  assign adapterPresentOut_n = 1'b0;
  assign adapterPresentOe = cur_reg.pgOn;
  assign indicatorOut_n = 2'h0;
  assign indicatorOe = cur_reg.ind;
endmodule
`default_nettype wire

// File: test/cfd_batt_model.sv
/* Removable pack model: output voltage and comparator levels.
   Assumes test currents and PWM state come from the sequencer. */
`timescale 1ns/10ps
`default_nettype none
module cfd_batt_model (
  input wire logic clk,
  input wire logic present,
  input wire integer packMv,
  input wire logic pwmEnable,
  input wire logic drainOn,
  input wire logic wakeOn,
  output logic batAboveRecharge,
  output logic batBelowShort,
  output logic outOvervoltage
);
  // ----------------------------------------
  // Output node: pack voltage or bare capacitor
  // ----------------------------------------
  int outMv = 4000;
  always @(posedge clk)
    if (present)
      outMv <= packMv;
    else if (drainOn)
      outMv <= (outMv > 400) ? outMv - 400 : 0;
    else if (wakeOn)
      outMv <= (outMv < 3800) ? outMv + 400 : 4200;
    else if (!pwmEnable && outMv >= 50)
      outMv <= outMv - 50;
  assign batAboveRecharge = outMv > 4100;
  assign batBelowShort = outMv < 2000;
  assign outOvervoltage = outMv > 4300;
endmodule
`default_nettype wire

// File: test/cfd_chk.sv
/* Concurrent checks on the charger sequencer's pin outputs.
   Assumes it is bound to the top module, one clock, async reset. */
`timescale 1ns/10ps
`default_nettype none
module cfd_chk #(
  parameter logic [31:0] FIRST_DRAIN_CYCLES = 32'h14,
  parameter logic [31:0] WAKE_CYCLES = 32'h14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic chargeEnable_n,
  input wire logic supplyAboveSleepExit,
  input wire logic batAboveRecharge,
  input wire logic outOvervoltage,
  input wire logic pwmEnable,
  input wire logic firstDrainOn,
  input wire logic wakeCurrentOn,
  input wire logic secondDrainOn,
  input wire logic removalSenseOn,
  input wire logic adapterPresentOe,
  input wire logic [1:0] indicatorOe
);
  // ----------------------------------------
  // Helpers and properties
  // ----------------------------------------
  logic [31:0] drainCnt;
  logic [31:0] wakeCnt;
  logic [3:0] srcOn;
  logic ovpHigh;
  assign srcOn = {firstDrainOn, wakeCurrentOn, secondDrainOn, removalSenseOn};
  assign ovpHigh = outOvervoltage & batAboveRecharge;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      drainCnt <= 32'h0;
      wakeCnt <= 32'h0;
    end
    else
    begin
      drainCnt <= firstDrainOn ? drainCnt + 32'h1 : 32'h0;
      wakeCnt <= wakeCurrentOn ? wakeCnt + 32'h1 : 32'h0;
    end
  AST_ONE_SRC: assert property ($onehot0(srcOn))
    else $error("two test currents on");
  AST_PWM_TEST: assert property (|srcOn |-> !pwmEnable)
    else $error("pwm on during test current");
  AST_CE_OFF: assert property (chargeEnable_n [*6] |-> !pwmEnable)
    else $error("charging while disabled");
  AST_PG_ON: assert property (supplyAboveSleepExit [*6] |-> adapterPresentOe)
    else $error("adapter pin off with supply");
  AST_PG_SLEEP: assert property (!supplyAboveSleepExit [*6] |-> !adapterPresentOe)
    else $error("adapter pin on in sleep");
  AST_OVP_OFF: assert property (ovpHigh [*6] |-> !pwmEnable && indicatorOe == 2'h0)
    else $error("overvoltage left stage on");
  AST_OVP_HOLD: assert property (ovpHigh && $fell(pwmEnable) ##1
    (batAboveRecharge && !chargeEnable_n) [*8] |-> !pwmEnable)
    else $error("overvoltage cleared early");
  AST_SENSE_HI: assert property (batAboveRecharge [*6] |-> !removalSenseOn)
    else $error("sense current on above recharge");
  AST_IND_CHG: assert property (indicatorOe[0] |-> pwmEnable && !indicatorOe[1])
    else $error("charging indicator wrong");
  AST_DRAIN_LEN: assert property (drainCnt <= FIRST_DRAIN_CYCLES + 32'h2)
    else $error("first drain too long");
  AST_WAKE_LEN: assert property (wakeCnt <= WAKE_CYCLES + 32'h2)
    else $error("wake current too long");
  cover property ($rose(wakeCurrentOn));
  cover property ($rose(secondDrainOn));
  cover property ($rose(removalSenseOn));
  cover property ($fell(pwmEnable) && ovpHigh);
endmodule
bind cfd_charger_seq cfd_chk #(.FIRST_DRAIN_CYCLES(FIRST_DRAIN_CYCLES),
  .WAKE_CYCLES(WAKE_CYCLES)) chk (.*);
`default_nettype wire

// File: test/testbench.sv
/* Scenario bench of the charger sequencer with a pack model.
   Assumes twenty-cycle test intervals and a 200-cycle safety timer. */
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin errTotal++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
`define WAITFOR(c, n) begin int k; k = 0; while (!(c) && k < (n)) begin @(posedge clk); k++; end end
module testbench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, rst_n, hsel, hwrite, hreadyout, irq, chargeEnable_n, pwmEnable, present;
  logic supplyAboveSleepExit, chargeTerminated, firstDrainOn, wakeCurrentOn, secondDrainOn;
  logic removalSenseOn, adapterPresentOe, batAboveRecharge, batBelowShort, outOvervoltage;
  logic [1:0] htrans, indicatorOe;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q;
  integer packMv;
  int errTotal = 0;
  int numChecks = 0;
  int cyc = 0;
  cfd_charger_seq #(.FIRST_DRAIN_CYCLES(32'h14), .WAKE_CYCLES(32'h14),
    .SECOND_DRAIN_CYCLES(32'h14), .SAFETY_CYCLES(44'hc8)) uut (.*, .hready(hreadyout),
    .hresp(), .adapterPresentOut_n(), .indicatorOut_n());
  cfd_batt_model pack (.clk(clk), .present(present), .packMv(packMv), .pwmEnable(pwmEnable),
    .drainOn(firstDrainOn | secondDrainOn), .wakeOn(wakeCurrentOn), .batAboveRecharge,
    .batBelowShort, .outOvervoltage);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      errTotal++;
      stopTest();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic restart(input integer mv);
    @(posedge clk);
    present <= 1'b1;
    packMv <= mv;
    chargeEnable_n <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(pwmEnable, 1'b0)
    chargeEnable_n <= 1'b0;
    `WAITFOR(pwmEnable === 1'b1, 10)
    `CHK(pwmEnable, 1'b1)
  endtask
  task automatic tPower();
    `WAITFOR(adapterPresentOe === 1'b1, 10)
    `CHK(adapterPresentOe, 1'b1)
    supplyAboveSleepExit <= 1'b0;
    `WAITFOR(adapterPresentOe === 1'b0, 10)
    `CHK(adapterPresentOe, 1'b0)
    supplyAboveSleepExit <= 1'b1;
  endtask
  task automatic tRegs();
    bus(1'b0, 32'h0, 32'h0, q);
    `CHK(q, 32'h0)
    bus(1'b0, 32'h4, 32'h0, q);
    `CHK(q, 32'h42)
    bus(1'b0, 32'h10, 32'h0, q);
    `CHK(q, 32'h0)
    bus(1'b1, 32'hc, 32'hf, q);
    bus(1'b0, 32'hc, 32'h0, q);
    `CHK(q, 32'hf)
    bus(1'b1, 32'h0, 32'h1, q);
    `WAITFOR(pwmEnable === 1'b0, 10)
    `CHK(pwmEnable, 1'b0)
    bus(1'b1, 32'h0, 32'h0, q);
  endtask
  task automatic tDetect();
    restart(4200);
    repeat (2) @(posedge clk);
    `CHK(indicatorOe, 2'h1)
    chargeTerminated <= 1'b1;
    `WAITFOR(indicatorOe === 2'h2, 10)
    `CHK({indicatorOe, pwmEnable}, 3'h4)
    chargeTerminated <= 1'b0;
    present <= 1'b0;
    `WAITFOR(firstDrainOn === 1'b1, 20)
    `CHK({firstDrainOn, pwmEnable}, 2'h2)
    repeat (17) @(posedge clk);
    `CHK(firstDrainOn, 1'b1)
    `WAITFOR(wakeCurrentOn === 1'b1, 10)
    `CHK(wakeCurrentOn, 1'b1)
    `WAITFOR(wakeCurrentOn === 1'b0, 30)
    bus(1'b0, 32'h8, 32'h0, q);
    `CHK({q[3], indicatorOe, irq}, 4'h9)
    bus(1'b1, 32'hc, 32'h0, q);
    @(posedge clk);
    `CHK(irq, 1'b0)
  endtask
  task automatic tPresent();
    @(posedge clk);
    present <= 1'b1;
    packMv <= 3900;
    `WAITFOR(pwmEnable === 1'b1, 60)
    `CHK({pwmEnable, indicatorOe}, 3'h5)
  endtask
  task automatic tRemoval();
    restart(4150);
    packMv <= 3900;
    `WAITFOR(secondDrainOn === 1'b1, 10)
    `CHK({secondDrainOn, pwmEnable}, 2'h2)
    `WAITFOR(firstDrainOn === 1'b1, 40)
    `CHK(firstDrainOn, 1'b1)
  endtask
  task automatic tTimer();
    restart(4200);
    `WAITFOR(pwmEnable === 1'b0, 220)
    `CHK({pwmEnable, indicatorOe, removalSenseOn}, 4'h0)
    restart(3800);
    `CHK(pwmEnable, 1'b1)
    `WAITFOR(removalSenseOn === 1'b1, 220)
    `CHK({removalSenseOn, pwmEnable}, 2'h2)
    packMv <= 4200;
    `WAITFOR(removalSenseOn === 1'b0, 10)
    `CHK(removalSenseOn, 1'b0)
    packMv <= 3800;
    `WAITFOR(firstDrainOn === 1'b1, 10)
    `CHK(firstDrainOn, 1'b1)
  endtask
  task automatic tOvp();
    restart(4200);
    packMv <= 4400;
    `WAITFOR(pwmEnable === 1'b0, 10)
    `CHK({pwmEnable, indicatorOe}, 3'h0)
    packMv <= 4200;
    repeat (10) @(posedge clk);
    `CHK(pwmEnable, 1'b0)
    packMv <= 4000;
    `WAITFOR(pwmEnable === 1'b1, 10)
    `CHK(pwmEnable, 1'b1)
  endtask
  task automatic stopTest();
    $display("checks %0d errors %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    {hsel, hwrite, chargeTerminated, chargeEnable_n} = 4'h1;
    {haddr, hwdata, htrans, hsize} = 69'h2;
    supplyAboveSleepExit = 1'b1;
    present = 1'b1;
    packMv = 4200;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    tPower();
    restart(4200);
    tRegs();
    tDetect();
    tPresent();
    tRemoval();
    tTimer();
    tOvp();
    stopTest();
  end
endmodule
`default_nettype wire
